/* File: hide_pkg.sv */
// Purpose: constants for the interrupt descriptor encoder
// Assumes: one 10 MHz clock, asynchronous active-low reset
// Notes: descriptor layout, event and error codes
package hide_pkg;
   localparam int DIR_BIT      = 31;
   localparam int GROUP_LO_MSB = 30;
   localparam int GROUP_LO_LSB = 29;
   localparam int CHAN_MSB     = 28;
   localparam int CHAN_LSB     = 24;
   localparam int EVENT_MSB    = 23;
   localparam int EVENT_LSB    = 20;
   localparam int ERROR_MSB    = 19;
   localparam int ERROR_LSB    = 16;
   localparam int GROUP_HI_BIT = 14;
   localparam int LEN_MSB      = 13;
   localparam int LEN_W        = 14;

   localparam logic [7:0] PAD_IDLE  = 8'h7E;
   localparam logic [7:0] PAD_ABORT = 8'hFF;

   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_PARITY = 4'h4;

   typedef enum logic [3:0] {
      EV_NONE     = 4'h0,
      EV_SERVICE_ACK = 4'h1,
      EV_BUF_END     = 4'h2,
      EV_MSG_END     = 4'h3,
      EV_PAD_END     = 4'h4,
      EV_ABORT    = 4'h5,
      EV_IDLE     = 4'h6,
      EV_FRAME_BACK  = 4'h7,
      EV_INC      = 4'h8,
      EV_DEC      = 4'h9,
      EV_FILT     = 4'hA
   } hide_event_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_REQ  = 2'b01
   } hide_wr_state_t;

   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

/* File: hide_pad_watch.sv */
// Purpose: watches received pad fill and frame state for change events
// Assumes: inputs come from logic on ref_clk
// Notes: first pad octet after reset only sets the reference
`timescale 1ns/1ps
module hide_pad_watch (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       pad_valid,
   input  wire logic [7:0] pad_octet,
   input  wire logic       out_of_frame,
   output logic            change_to_abort,
   output logic            change_to_idle,
   output logic            frame_recovery
);
   typedef struct packed {
      logic [7:0] last_pad;
      logic       have_pad;
      logic       oof_q;
      logic       abt;
      logic       idl;
      logic       rec;
   } hide_pw_t;

   hide_pw_t st;
   hide_pw_t next_st;

   always_comb begin
      next_st     = st;
      next_st.abt = 1'b0;
      next_st.idl = 1'b0;
      next_st.oof_q = out_of_frame;
      next_st.rec = st.oof_q & ~out_of_frame;
      if (pad_valid) begin
         next_st.have_pad = 1'b1;
         next_st.last_pad = pad_octet;
         if (st.have_pad && st.last_pad == hide_pkg::PAD_IDLE && pad_octet == hide_pkg::PAD_ABORT) begin
            next_st.abt = 1'b1;
         end
         if (st.have_pad && st.last_pad == hide_pkg::PAD_ABORT && pad_octet == hide_pkg::PAD_IDLE) begin
            next_st.idl = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign change_to_abort = st.abt;
   assign change_to_idle  = st.idl;
   assign frame_recovery  = st.rec;
endmodule // hide_pad_watch

/* File: hide_word_pack.sv */
// Purpose: packs source, event, error and length into a descriptor word
// Assumes: pure combinational packing
// Notes: length field shares no bits with group msb
`timescale 1ns/1ps
module hide_word_pack (
   input  wire logic                    direction,
   input  wire logic [2:0]              group_number,
   input  wire logic [4:0]              channel_number,
   input  wire logic [3:0]              event_code,
   input  wire logic [3:0]              error_code,
   input  wire logic [hide_pkg::LEN_W-1:0] buffer_length_field,
   output logic [31:0]                  word
);
   always_comb begin
      word = hide_pkg::WORD_ZERO;
      word[hide_pkg::DIR_BIT] = direction;
      word[hide_pkg::GROUP_LO_MSB:hide_pkg::GROUP_LO_LSB] = group_number[1:0];
      word[hide_pkg::CHAN_MSB:hide_pkg::CHAN_LSB] = channel_number;
      word[hide_pkg::GROUP_HI_BIT] = group_number[2];
      word[hide_pkg::EVENT_MSB:hide_pkg::EVENT_LSB] = event_code;
      word[hide_pkg::ERROR_MSB:hide_pkg::ERROR_LSB] = error_code;
      word[hide_pkg::LEN_MSB:0] = buffer_length_field;
   end
endmodule // hide_word_pack

/* File: hide_encoder.sv */
// Purpose: chooses one event per cycle and posts a descriptor word
// Assumes: event strobes are one-cycle pulses on ref_clk
// Notes: a pending word is held until the bus master takes it
`timescale 1ns/1ps
module hide_encoder (
   input  wire logic                         ref_clk,
   input  wire logic                         reset_n,
   input  wire logic                         direction,
   input  wire logic [2:0]                   group_number,
   input  wire logic [4:0]                   channel_number,
   input  wire logic                         ss7_mode,
   input  wire logic                         sreq_done,
   input  wire logic                         sreq_error,
   input  wire logic                         buffer_done,
   input  wire logic                         end_of_buffer_irq_flag,
   input  wire logic [hide_pkg::LEN_W-1:0]   byte_count,
   input  wire logic                         last_octet_in_buffer,
   input  wire logic                         tx_last_bit_out,
   input  wire logic                         rx_frame_stored,
   input  wire logic                         pad_done,
   input  wire logic [7:0]                   pad_count,
   input  wire logic                         padfill_irq_enable,
   input  wire logic                         pad_valid,
   input  wire logic [7:0]                   pad_octet,
   input  wire logic                         out_of_frame,
   input  wire logic                         error_monitor_increment,
   input  wire logic                         error_monitor_decrement,
   input  wire logic                         message_repeat,
   input  wire logic [3:0]                   error_code,
   input  wire logic                         queue_ready,
   output logic                              queue_valid,
   output logic [31:0]                       queue_word,
   output logic                              store_discard,
   output logic                              busy
);
   typedef struct packed {
      hide_pkg::hide_wr_state_t  state;
      logic [31:0]               word;
      logic                      discard;
   } hide_enc_t;

   hide_enc_t st;
   hide_enc_t next_st;

   logic       chg_abort;
   logic       chg_idle;
   logic       frm_rec;
   logic [3:0] ev;
   logic [3:0] err;
   logic [hide_pkg::LEN_W-1:0] len;
   logic [31:0] packed_word;
   logic        msg_end_hit;

   hide_pad_watch u_pad (
      .ref_clk         (ref_clk),
      .reset_n         (reset_n),
      .pad_valid       (pad_valid),
      .pad_octet       (pad_octet),
      .out_of_frame    (out_of_frame),
      .change_to_abort (chg_abort),
      .change_to_idle  (chg_idle),
      .frame_recovery  (frm_rec)
   );

   // transmit ends when data leaves the port, receive once memory holds the frame
   assign msg_end_hit = buffer_done & last_octet_in_buffer &
                        (direction ? tx_last_bit_out : rx_frame_stored);

   // fixed priority keeps at most one event in the word
   always_comb begin
      ev  = hide_pkg::EV_NONE;
      err = error_code;
      len = '0;
      if (sreq_done && !sreq_error) begin
         ev = hide_pkg::EV_SERVICE_ACK;
      end else if (sreq_done && sreq_error) begin
         err = hide_pkg::ERR_PARITY;
      end else if (msg_end_hit) begin
         ev  = hide_pkg::EV_MSG_END;
         len = byte_count;
      end else if (buffer_done && end_of_buffer_irq_flag) begin
         ev  = hide_pkg::EV_BUF_END;
         len = byte_count;
      end else if (direction && pad_done && pad_count != 8'h00 && padfill_irq_enable) begin
         ev = hide_pkg::EV_PAD_END;
      end else if (!direction && chg_abort) begin
         ev = hide_pkg::EV_ABORT;
      end else if (!direction && chg_idle) begin
         ev = hide_pkg::EV_IDLE;
      end else if (frm_rec) begin
         ev = hide_pkg::EV_FRAME_BACK;
      end else if (ss7_mode && error_monitor_increment) begin
         ev = hide_pkg::EV_INC;
      end else if (ss7_mode && error_monitor_decrement) begin
         ev = hide_pkg::EV_DEC;
      end else if (ss7_mode && message_repeat) begin
         ev = hide_pkg::EV_FILT;
      end
   end

   hide_word_pack u_pack (
      .direction           (direction),
      .group_number        (group_number),
      .channel_number      (channel_number),
      .event_code          (ev),
      .error_code          (err),
      .buffer_length_field (len),
      .word                (packed_word)
   );

   // events arriving while a word waits are dropped; busy tells the source
   always_comb begin
      next_st         = st;
      // a repeat is dropped even if the queue is busy; the store must never see it
      next_st.discard = ss7_mode & message_repeat;
      case (st.state)
         hide_pkg::WR_IDLE: begin
            if (ev != hide_pkg::EV_NONE || err != hide_pkg::ERR_NONE) begin
               next_st.word  = packed_word;
               next_st.state = hide_pkg::WR_REQ;
            end
         end
         hide_pkg::WR_REQ: begin
            if (queue_ready) begin
               next_st.state = hide_pkg::WR_IDLE;
            end
         end
         default: next_st.state = hide_pkg::WR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign queue_valid   = (st.state == hide_pkg::WR_REQ);
   assign queue_word    = st.word;
   assign store_discard = st.discard;
   assign busy          = (st.state == hide_pkg::WR_REQ);
endmodule // hide_encoder

/* File: hide_encoder_monitor.sv */
// Purpose: port assertions for the descriptor encoder
// Assumes: one ref_clk domain, bench keeps source fields steady per event
// Notes: pad and frame events are left to the bench, their latency differs
`timescale 1ns/1ps
module hide_encoder_monitor (
   input wire logic ref_clk, reset_n, direction, ss7_mode, sreq_done, sreq_error, buffer_done,
   input wire logic end_of_buffer_irq_flag, last_octet_in_buffer, tx_last_bit_out, rx_frame_stored,
   input wire logic pad_done, padfill_irq_enable, pad_valid, out_of_frame, error_monitor_increment,
   input wire logic error_monitor_decrement, message_repeat, queue_ready, queue_valid, store_discard, busy,
   input wire logic [2:0]                   group_number,
   input wire logic [4:0]                   channel_number,
   input wire logic [hide_pkg::LEN_W-1:0]   byte_count,
   input wire logic [7:0]                   pad_count, pad_octet,
   input wire logic [3:0]                   error_code,
   input wire logic [31:0]                  queue_word
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_word_stands: assert property (queue_valid && !queue_ready |=> queue_valid && $stable(queue_word))
      else $error("descriptor word changed before it was taken");
   a_reserved_code: assert property (queue_valid |-> queue_word[23:20] <= 4'hA)
      else $error("reserved event code posted");
   a_service_acknowledge_posts: assert property (!queue_valid && sreq_done && !sreq_error |=> queue_word[23:16] == 8'h10)
      else $error("service acknowledge not posted");
   a_sreq_fails: assert property (!queue_valid && sreq_done && sreq_error |=> queue_word[23:16] == {4'h0, hide_pkg::ERR_PARITY})
      else $error("failed service request word wrong");
   a_buf_end_length: assert property (!queue_valid && !sreq_done && buffer_done && end_of_buffer_irq_flag
      && !last_octet_in_buffer |=> queue_word[23:20] == 4'h2 && queue_word[13:0] == $past(byte_count))
      else $error("end of buffer word wrong");
   a_msg_end_tx: assert property (!queue_valid && !sreq_done && buffer_done && last_octet_in_buffer
      && direction && tx_last_bit_out |=> queue_valid && queue_word[23:20] == 4'h3)
      else $error("transmit end of message missing");
   a_msg_end_rx: assert property (!queue_valid && !sreq_done && buffer_done && !direction
      && !rx_frame_stored && !end_of_buffer_irq_flag |=> !queue_valid)
      else $error("receive end of message before frame stored");
   a_discard_filt: assert property (ss7_mode && message_repeat |=> store_discard)
      else $error("repeated message not discarded");
   a_source_fields: assert property ($rose(queue_valid) && $stable(group_number) |-> queue_word[31] == direction
      && queue_word[30:29] == group_number[1:0] && queue_word[28:24] == channel_number && queue_word[14] == group_number[2])
      else $error("source fields misplaced");
endmodule // hide_encoder_monitor

/* File: hide_host_model.sv */
// Purpose: host queue side taking descriptor words
// Assumes: ready given after a chosen stall
// Notes: ready lasts one cycle, so a word is never counted twice
`timescale 1ns/1ps
module hide_host_model (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        queue_valid,
   input  wire logic [31:0] queue_word,
   input  wire logic [3:0]  stall,
   output logic             queue_ready,
   output logic [31:0]      got_word,
   output logic [7:0]       got_count
);
   logic [3:0] wait_cnt;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         queue_ready <= 1'b0;
         wait_cnt <= 4'h0;
         got_word <= 32'h0000_0000;
         got_count <= 8'h00;
      end else if (queue_ready) begin
         queue_ready <= 1'b0;
         wait_cnt <= 4'h0;
         got_word <= queue_word;
         got_count <= got_count + 8'h01;
      end else if (queue_valid) begin
         if (wait_cnt >= stall) queue_ready <= 1'b1;
         else wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // hide_host_model

/* File: hide_encoder_tb.sv */
// Purpose: self-checking bench for the descriptor encoder
// Assumes: inputs change at the falling edge
// Notes: error_code held at zero
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin fail_count++; $display("MISMATCH %s exp %h got %h", nm, ex, sn); end end
`define PULSE(s) begin @(negedge ref_clk); s = 1'b1; @(negedge ref_clk); s = 1'b0; end
module hide_encoder_tb;
   logic ref_clk, reset_n, direction, ss7_mode, sreq_done, sreq_error, buffer_done, pad_done, pad_valid;
   logic end_of_buffer_irq_flag, last_octet_in_buffer, tx_last_bit_out, rx_frame_stored, out_of_frame;
   logic padfill_irq_enable, error_monitor_increment, error_monitor_decrement, message_repeat;
   logic queue_ready, queue_valid, store_discard, busy;
   logic [2:0]  group_number;
   logic [4:0]  channel_number;
   logic [hide_pkg::LEN_W-1:0] byte_count;
   logic [7:0]  pad_count, pad_octet, got_count;
   logic [3:0]  error_code, stall;
   logic [31:0] queue_word, got_word;
   int          fail_count, compares, cycles;
   hide_encoder hide_encoder_i (.*);
   hide_host_model hide_host_model_i (.*);
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         close_out();
      end
   end
   task close_out;
      if (fail_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task expect_word(input logic [3:0] ev, input logic [3:0] er, input logic chk_len);
      logic [7:0] base;
      int n;
      base = got_count;
      n = 0;
      while (got_count == base && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      `CHK("count", base + 8'h01, got_count)
      `CHK("word", {direction, group_number[1:0], channel_number, ev, er, 1'b0, group_number[2]}, got_word[31:14])
      if (chk_len) `CHK("length", byte_count, got_word[13:0])
   endtask
   task expect_none;
      logic [7:0] base;
      base = got_count;
      repeat (8) @(negedge ref_clk);
      `CHK("no word", base, got_count)
   endtask
   task t_service;
      for (int i = 0; i < 3; i++) begin
         direction = i[0];
         group_number = 3'(3 * i + 1);
         channel_number = 5'(31 - 11 * i);
         stall = 4'(2 * i);
         `PULSE(sreq_done) expect_word(4'h1, 4'h0, 1'b0);
      end
      sreq_error = 1'b1;
      `PULSE(sreq_done) expect_word(4'h0, hide_pkg::ERR_PARITY, 1'b0);
      sreq_error = 1'b0;
   endtask
   task t_buffer;
      direction = 1'b1;
      end_of_buffer_irq_flag = 1'b1;
      byte_count = 14'h3FFF;
      `PULSE(buffer_done) expect_word(4'h2, 4'h0, 1'b1);
      end_of_buffer_irq_flag = 1'b0;
      byte_count = 14'h0001;
      `PULSE(buffer_done) expect_none();
      last_octet_in_buffer = 1'b1;
      `PULSE(buffer_done) expect_none();
      tx_last_bit_out = 1'b1;
      `PULSE(buffer_done) expect_word(4'h3, 4'h0, 1'b1);
      direction = 1'b0;
      `PULSE(buffer_done) expect_none();
      rx_frame_stored = 1'b1;
      `PULSE(buffer_done) expect_word(4'h3, 4'h0, 1'b1);
      last_octet_in_buffer = 1'b0;
   endtask
   task t_pad;
      direction = 1'b1;
      pad_count = 8'h03;
      `PULSE(pad_done) expect_none();
      padfill_irq_enable = 1'b1;
      `PULSE(pad_done) expect_word(4'h4, 4'h0, 1'b0);
      pad_count = 8'h00;
      `PULSE(pad_done) expect_none();
      direction = 1'b0;
      pad_octet = hide_pkg::PAD_IDLE;
      `PULSE(pad_valid) expect_none();
      pad_octet = hide_pkg::PAD_ABORT;
      `PULSE(pad_valid) expect_word(4'h5, 4'h0, 1'b0);
      `PULSE(pad_valid) expect_none();
      pad_octet = hide_pkg::PAD_IDLE;
      `PULSE(pad_valid) expect_word(4'h6, 4'h0, 1'b0);
      out_of_frame = 1'b1;
      expect_none();
      out_of_frame = 1'b0;
      expect_word(4'h7, 4'h0, 1'b0);
   endtask
   task t_ss7;
      `PULSE(error_monitor_increment) expect_none();
      ss7_mode = 1'b1;
      `PULSE(error_monitor_increment) expect_word(4'h8, 4'h0, 1'b0);
      `PULSE(error_monitor_decrement) expect_word(4'h9, 4'h0, 1'b0);
      `PULSE(message_repeat) `CHK("discard", 1'b1, store_discard)
      `CHK("busy", 1'b1, busy)
      expect_word(4'hA, 4'h0, 1'b0);
      `CHK("busy after", 1'b0, busy)
      `CHK("discard after", 1'b0, store_discard)
   endtask
   initial begin
      {reset_n, direction, ss7_mode, sreq_done, sreq_error, buffer_done, pad_done, pad_valid} = 8'h00;
      {end_of_buffer_irq_flag, last_octet_in_buffer, tx_last_bit_out, rx_frame_stored, out_of_frame} = 5'h00;
      {padfill_irq_enable, error_monitor_increment, error_monitor_decrement, message_repeat} = 4'h0;
      {group_number, channel_number, byte_count, pad_count, pad_octet} = 38'h0;
      error_code = 4'h0;
      stall = 4'h1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) reset_n = 1'b1;
      t_service();
      t_buffer();
      t_pad();
      t_ss7();
      close_out();
   end
endmodule // hide_encoder_tb
bind hide_encoder hide_encoder_monitor hide_encoder_monitor_i (.*);
